// ===== hdl/flash_cmd_decoder.sv
// Resume, burst-wrap and write-enable command decoder of a serial flash
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.svh"

// Notes on behaviour
// - Opcodes 7Ah and D0h both mean program/erase resume.
// - Resume acts only if a suspended flag is set and busy is clear.
// - Resume ignores the write-latch flag.
// - Resume frame is an eight-clock serial opcode, MSB first; trailing whole bytes still let it act.
// - Resume clears the matching suspended flag; summary clears when both clear.
// - Resume sets the busy flag.
// - Suspended operation restarts within the resume latency after chip select rises.
// - Suspends are ignored while a resume takes effect.
// - With both suspended, resume restarts the program first.
// - Wrap setting from 77h applies to later EBh and E7h reads.
// - Wrapped read runs to window end, then from window start.
// - Wrap frame: serial opcode, then address and data on four lines.
// - Three address bytes over six clocks follow, value ignored.
// - Wrap byte uses only bits six to four.
// - Codes 00..11 give 8, 16, 32, 64 bytes; disable bit stops wrapping.
// - Wrap setting persists until another 77h changes it.
// - Chip select ending off a byte boundary leaves wrap unchanged.
// - Complete 06h sets the write-latch flag at chip select rise.
// - Program, erase, OTP and status writes refused without write latch.
// - Write-enable frame is an eight-clock serial opcode, MSB first.
// - Suspend sets summary and suspended flag, clears busy.
module flash_cmd_decoder
   import flash_cmd_pkg::*;
#(
   parameter int RESUME_CYCLES = `RESUME_CYCLES
) (
   // Clock and reset
   input  wire logic        clock,
   input  wire logic        rst,
   // Serial pins from the host
   input  wire logic        csN,
   input  wire logic        sck,
   input  wire logic [3:0]  io,
   // Program/erase engine events
   input  wire logic        suspendReq,
   input  wire logic        suspendIsProgram,
   input  wire logic        opDone,
   input  wire logic        writeLatchClear,
   // Protected command requests
   input  wire logic        protCmdReq,
   output logic             protCmdGo,
   output logic             protCmdRefused,
   // Restart strobes to the engines and the resume window flag
   output logic             restartProgram,
   output logic             restartErase,
   output logic             resumeInEffect,
   // Status and wrap setting
   output status_t          status,
   output logic [2:0]       wrapSettingBits,
   output logic             quadReadActive,
   // Read address generator
   input  wire logic        addrLoad,
   input  wire logic [23:0] loadAddr,
   input  wire logic        addrStep,
   output logic [23:0]      readAddr
);

   // ****************************************
   // Helpers
   // ****************************************

   // Mask of the address bits that advance inside a wrap window
   function automatic logic [23:0] wrapMask(input logic [2:0] bits);
      logic [23:0] m;
      m = 24'h000007;
      case (bits[2:1])
         2'b00: m = 24'h000007;
         2'b01: m = 24'h00000f;
         2'b10: m = 24'h00001f;
         2'b11: m = 24'h00003f;
         default: m = 24'h000007;
      endcase
      return m;
   endfunction

   // True when the opcode is one of the resume codes
   function automatic logic isResume(input logic [7:0] op);
      return (op == `OPC_RESUME_A) || (op == `OPC_RESUME_B);
   endfunction

   // ****************************************
   // State
   // ****************************************

   state_t      s;
   state_t      next_s;

   logic        sckRise;
   logic        csRise;
   logic        frameOn;
   logic        byteEnd;
   logic        wrapOk;
   logic [7:0]  newByte;
   logic [23:0] mask;
   logic [23:0] stepped;

   // Pin edges, seen only from the second synchroniser stage
   assign frameOn = ~s.csS2;
   assign sckRise = frameOn & s.sckS2 & ~s.sckPrev;
   assign csRise  = s.csS2 & ~s.csPrev;
   // Serial framing ends on a byte boundary with a whole opcode in
   assign byteEnd = (s.phase != PH_OPCODE) && (s.clocks[2:0] == 3'h0);
   // Quad phase moves four bits a clock, so an even count is a whole byte
   assign wrapOk  = (s.phase == PH_SKIP) && (s.clocks >= `WRAP_MIN_CLOCKS)
                    && ~s.clocks[0];

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      next_s = s;
      newByte = 8'h00;
      mask = wrapMask(s.wrapSettingBits);
      stepped = 24'h000000;

      // Two-stage synchronisers for every pin
      next_s.csS1    = csN;
      next_s.csS2    = s.csS1;
      next_s.csPrev  = s.csS2;
      next_s.sckS1   = sck;
      next_s.sckS2   = s.sckS1;
      next_s.sckPrev = s.sckS2;
      next_s.ioS1    = io;
      next_s.ioS2    = s.ioS1;

      // One-cycle strobes
      next_s.restartProgram = 1'b0;
      next_s.restartErase   = 1'b0;
      next_s.protGo         = 1'b0;
      next_s.protRefused    = 1'b0;

      // Serial shifting during a frame
      if (sckRise) begin
         next_s.clocks = s.clocks + 6'h01;
         case (s.phase)
            PH_OPCODE: begin
               newByte = {s.shift[6:0], s.ioS2[0]};
               next_s.shift = newByte;
               if (s.clocks == `OPCODE_CLOCKS - 6'h01) begin
                  next_s.opcode = newByte;
                  if (newByte == `OPC_SET_WRAP) begin
                     next_s.phase = PH_ADDR;
                  end else begin
                     next_s.phase = PH_SKIP;
                  end
                  if (newByte == `OPC_QUAD_READ_A || newByte == `OPC_QUAD_READ_B) begin
                     next_s.quadRead = 1'b1;
                  end
               end
            end
            PH_ADDR: begin
               // Address value is not kept
               if (s.clocks == `WRAP_ADDR_LAST) begin
                  next_s.phase = PH_WRAP;
               end
            end
            PH_WRAP: begin
               next_s.shift = {s.shift[3:0], s.ioS2};
               if (s.clocks == `WRAP_DATA_LAST) begin
                  next_s.phase = PH_SKIP;
               end
            end
            PH_SKIP: begin
               next_s.phase = PH_SKIP;
            end
            default: begin
               next_s.phase = PH_SKIP;
            end
         endcase
      end

      // Resume latency window
      if (s.resumeCnt != 16'h0000) begin
         next_s.resumeCnt = s.resumeCnt - 16'h0001;
      end

      // Engine events on the status flags
      if (opDone) begin
         next_s.status.opInProgressFlag = 1'b0;
      end
      if (writeLatchClear) begin
         next_s.status.writeLatchFlag = 1'b0;
      end
      if (suspendReq && s.status.opInProgressFlag && s.resumeCnt == 16'h0000) begin
         next_s.status.suspendSummaryFlag = 1'b1;
         next_s.status.opInProgressFlag   = 1'b0;
         if (suspendIsProgram) begin
            next_s.status.programSuspendedFlag = 1'b1;
         end else begin
            next_s.status.eraseSuspendedFlag = 1'b1;
         end
      end

      // Protected commands need the write latch
      if (protCmdReq) begin
         next_s.protGo      = s.status.writeLatchFlag;
         next_s.protRefused = ~s.status.writeLatchFlag;
         // An accepted command starts its engine, so the device turns busy
         if (s.status.writeLatchFlag) begin
            next_s.status.opInProgressFlag = 1'b1;
         end
      end

      // Commands act when chip select rises
      if (csRise) begin
         if (byteEnd && s.opcode == `OPC_WRITE_ENABLE) begin
            next_s.status.writeLatchFlag = 1'b1;
         end
         // Write latch plays no part in this decision
         if (byteEnd && isResume(s.opcode)
             && (s.status.eraseSuspendedFlag || s.status.programSuspendedFlag)
             && ~s.status.opInProgressFlag) begin
            next_s.status.opInProgressFlag = 1'b1;
            next_s.resumeCnt = 16'(RESUME_CYCLES);
            if (s.status.programSuspendedFlag) begin
               next_s.status.programSuspendedFlag = 1'b0;
               next_s.restartProgram = 1'b1;
               if (~s.status.eraseSuspendedFlag) begin
                  next_s.status.suspendSummaryFlag = 1'b0;
               end
            end else begin
               next_s.status.eraseSuspendedFlag = 1'b0;
               next_s.status.suspendSummaryFlag = 1'b0;
               next_s.restartErase = 1'b1;
            end
         end
         if (wrapOk && s.opcode == `OPC_SET_WRAP) begin
            next_s.wrapSettingBits = s.shift[`WRAP_FIELD_HI:`WRAP_FIELD_LO];
         end
      end

      // Frame state clears while chip select is high
      if (~frameOn) begin
         next_s.phase    = PH_OPCODE;
         next_s.clocks   = 6'h00;
         next_s.quadRead = 1'b0;
         if (~csRise) begin
            next_s.opcode = 8'h00;
         end
      end

      // Read address walk, wrapping inside the aligned window
      if (addrLoad) begin
         next_s.readAddr = loadAddr;
      end else if (addrStep) begin
         stepped = s.readAddr + 24'h000001;
         if (s.quadRead && ~s.wrapSettingBits[0]) begin
            next_s.readAddr = (s.readAddr & ~mask) | (stepped & mask);
         end else begin
            next_s.readAddr = stepped;
         end
      end
   end

   // ****************************************
   // State register
   // ****************************************
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.csS1 <= 1'b1;
         s.csS2 <= 1'b1;
         s.csPrev <= 1'b1;
         s.phase <= PH_OPCODE;
         s.wrapSettingBits <= `WRAP_RESET;
      end else begin
         s <= next_s;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign protCmdGo       = s.protGo;
   assign protCmdRefused  = s.protRefused;
   assign restartProgram  = s.restartProgram;
   assign restartErase    = s.restartErase;
   assign resumeInEffect  = (s.resumeCnt != 16'h0000);
   assign status          = s.status;
   assign wrapSettingBits = s.wrapSettingBits;
   assign quadReadActive  = s.quadRead;
   assign readAddr        = s.readAddr;

endmodule // flash_cmd_decoder

`default_nettype wire

// ===== include/flash_cmd_consts.svh
// Constants of the serial flash resume, burst-wrap and write-enable decoder
`ifndef FLASH_CMD_CONSTS_SVH
`define FLASH_CMD_CONSTS_SVH

// ****************************************
// Opcodes
// ****************************************
`define OPC_RESUME_A     8'h7a
`define OPC_RESUME_B     8'hd0
`define OPC_SET_WRAP     8'h77
`define OPC_WRITE_ENABLE 8'h06
`define OPC_QUAD_READ_A  8'heb
`define OPC_QUAD_READ_B  8'he7

// ****************************************
// Frame layout, in serial clocks
// ****************************************
`define OPCODE_CLOCKS    6'h08
`define WRAP_ADDR_LAST   6'h0d
`define WRAP_DATA_LAST   6'h0f
`define WRAP_MIN_CLOCKS  6'h10

// ****************************************
// Field positions and reset values
// ****************************************
`define WRAP_FIELD_HI    6
`define WRAP_FIELD_LO    4
`define WRAP_RESET       3'h1

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_PS    4000
`define RESUME_LATENCY_NS 5000
`define RESUME_CYCLES    ((`RESUME_LATENCY_NS * 1000) / `CLK_PERIOD_PS)

`endif

// ===== include/flash_cmd_pkg.sv
// Types shared by the serial flash command decoder
package flash_cmd_pkg;

   // Serial frame decode phase
   typedef enum logic [1:0] {
      PH_OPCODE = 2'b00,
      PH_ADDR   = 2'b01,
      PH_WRAP   = 2'b10,
      PH_SKIP   = 2'b11
   } phase_t;

   // Status flags seen by the host through status reads
   typedef struct packed {
      logic eraseSuspendedFlag;
      logic programSuspendedFlag;
      logic suspendSummaryFlag;
      logic opInProgressFlag;
      logic writeLatchFlag;
   } status_t;

   // Whole state of the decoder
   typedef struct packed {
      logic        csS1;
      logic        csS2;
      logic        csPrev;
      logic        sckS1;
      logic        sckS2;
      logic        sckPrev;
      logic [3:0]  ioS1;
      logic [3:0]  ioS2;
      phase_t      phase;
      logic [5:0]  clocks;
      logic [7:0]  shift;
      logic [7:0]  opcode;
      logic [2:0]  wrapSettingBits;
      logic        quadRead;
      status_t     status;
      logic [15:0] resumeCnt;
      logic        restartProgram;
      logic        restartErase;
      logic        protGo;
      logic        protRefused;
      logic [23:0] readAddr;
   } state_t;

endpackage

// ===== tb/flash_cmd_checker.sv
// Concurrent checks on the ports of the flash command decoder
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_checker
   import flash_cmd_pkg::*;
#(
   parameter int RESUME_CYCLES = 20
) (
   // Clock and reset
   input wire logic        clock,
   input wire logic        rst,
   // Stimulus seen by the decoder
   input wire logic        csN,
   input wire logic        suspendReq,
   input wire logic        suspendIsProgram,
   input wire logic        protCmdReq,
   input wire logic        addrLoad,
   input wire logic [23:0] loadAddr,
   input wire logic        addrStep,
   // Decoder outputs
   input wire logic        protCmdGo,
   input wire logic        protCmdRefused,
   input wire logic        restartProgram,
   input wire logic        restartErase,
   input wire logic        resumeInEffect,
   input wire status_t     status,
   input wire logic [2:0]  wrapSettingBits,
   input wire logic        quadReadActive,
   input wire logic [23:0] readAddr
);
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   logic [15:0] lockCnt;
   logic [23:0] winMask;
   logic [23:0] nextAddr;
   // Next read address, kept inside the aligned window while wrapping
   always_comb begin
      winMask = (24'h000008 << wrapSettingBits[2:1]) - 24'h000001;
      nextAddr = readAddr + 24'h000001;
      if (quadReadActive && !wrapSettingBits[0])
         nextAddr = (readAddr & ~winMask) | (nextAddr & winMask);
   end
   // Length of the suspend lockout
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         lockCnt <= 16'h0000;
      else
         lockCnt <= resumeInEffect ? lockCnt + 16'h0001 : 16'h0000;
   end
   a_prot_gate: assert property (
      protCmdReq |=> protCmdGo == $past(status.writeLatchFlag) && protCmdRefused != protCmdGo)
      else $error("protected command gate wrong");
   a_restart_state: assert property (
      restartProgram |-> status.opInProgressFlag && !status.programSuspendedFlag
      && status.suspendSummaryFlag == status.eraseSuspendedFlag) else $error("resume flags wrong");
   a_restart_cause: assert property (
      restartProgram |-> $past(status.programSuspendedFlag) && !$past(status.opInProgressFlag))
      else $error("program restart without suspension");
   a_erase_order: assert property (
      restartErase |-> !status.eraseSuspendedFlag && !status.suspendSummaryFlag
      && status.opInProgressFlag
      && $past(status.eraseSuspendedFlag) && !$past(status.programSuspendedFlag))
      else $error("erase restart wrong");
   a_suspend_flags: assert property (
      suspendReq && status.opInProgressFlag && !resumeInEffect |=> status.suspendSummaryFlag
      && !status.opInProgressFlag && ($past(suspendIsProgram) ? status.programSuspendedFlag
      : status.eraseSuspendedFlag)) else $error("suspend flags wrong");
   a_lock_ignore: assert property (
      resumeInEffect && suspendReq |=> $stable(status.programSuspendedFlag)
      && $stable(status.eraseSuspendedFlag)) else $error("suspend taken in lockout");
   a_lock_length: assert property (
      $fell(resumeInEffect) |-> lockCnt == 16'(RESUME_CYCLES)) else $error("lockout length wrong");
   a_wrap_frame: assert property (
      $changed(wrapSettingBits) |-> $past(csN, 2)) else $error("wrap changed inside a frame");
   a_addr_next: assert property (
      addrLoad || addrStep |=> readAddr == $past(addrLoad ? loadAddr : nextAddr))
      else $error("read address wrong");
   // Main scenarios
   c_erase_restart: cover property (restartErase);
   c_refused: cover property (protCmdRefused);
   c_wrap_step: cover property (quadReadActive && addrStep && !wrapSettingBits[0]);
endmodule // flash_cmd_checker
bind flash_cmd_decoder flash_cmd_checker #(.RESUME_CYCLES(RESUME_CYCLES)) checks (.*);
`default_nettype wire

// ===== tb/spi_host_model.sv
// Host serial controller driving the flash pins
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
   // Clock
   input wire logic   clock,
   // Serial pins
   output logic       csN,
   output logic       sck,
   output logic [3:0] io
);
   initial begin
      csN = 1'b1;
      sck = 1'b0;
      io = 4'h5;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // One serial clock: data set while low, taken on the rise
   task automatic sckCycle(input logic [3:0] v);
      io = v;
      tick(4);
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
   endtask
   // Released lines show the inverse of the last value
   task automatic endFrame;
      tick(4);
      csN = 1'b1;
      io = ~io;
      tick(8);
   endtask
   task automatic frame(input logic [7:0] op, input int opClk, input logic [31:0] quad,
                        input int quadClk, input bit hold);
      csN = 1'b0;
      tick(4);
      for (int i = 0; i < opClk; i++) sckCycle({3'h0, op[7 - i]});
      for (int i = 0; i < quadClk; i++) sckCycle(quad[31 - 4 * i -: 4]);
      if (!hold) endFrame();
   endtask
endmodule // spi_host_model
`default_nettype wire

// ===== tb/flash_resume_wrap_write_enable_tb_top.sv
// Self-checking bench of the flash command decoder
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_consts.svh"
module flash_resume_wrap_write_enable_tb_top;
   import flash_cmd_pkg::*;
   logic        clock, rst, suspendReq, suspendIsProgram, opDone, writeLatchClear;
   logic        protCmdReq, addrLoad, addrStep, protCmdGo, protCmdRefused, restartProgram;
   logic        restartErase, resumeInEffect, quadReadActive, csN, sck;
   logic [3:0]  io;
   logic [23:0] loadAddr, readAddr;
   logic [2:0]  wrapSettingBits;
   status_t     status;
   int          errCount, testsRun;
   spi_host_model host (.clock(clock), .csN(csN), .sck(sck), .io(io));
   flash_cmd_decoder #(.RESUME_CYCLES(20)) dut (.clock(clock), .rst(rst), .csN(csN), .sck(sck),
      .io(io), .suspendReq(suspendReq), .suspendIsProgram(suspendIsProgram), .opDone(opDone),
      .writeLatchClear(writeLatchClear), .protCmdReq(protCmdReq), .protCmdGo(protCmdGo),
      .protCmdRefused(protCmdRefused), .restartProgram(restartProgram),
      .restartErase(restartErase), .resumeInEffect(resumeInEffect), .status(status),
      .wrapSettingBits(wrapSettingBits), .quadReadActive(quadReadActive),
      .addrLoad(addrLoad), .loadAddr(loadAddr), .addrStep(addrStep), .readAddr(readAddr));
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      testsRun++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   localparam int SUSPEND   = 0;
   localparam int DONE      = 1;
   localparam int LATCH_CLR = 2;
   // One-cycle pulse on an engine input, then two quiet cycles
   task automatic strobe(input int which);
      case (which)
         SUSPEND: suspendReq = 1'b1;
         DONE:    opDone = 1'b1;
         default: writeLatchClear = 1'b1;
      endcase
      host.tick(1);
      suspendReq = 1'b0;
      opDone = 1'b0;
      writeLatchClear = 1'b0;
      host.tick(2);
   endtask
   // Protected command request; the answer stands in the cycle after it is taken
   task automatic protReq(input logic expGo);
      protCmdReq = 1'b1;
      host.tick(1);
      chk("prot go", 24'(expGo), 24'(protCmdGo));
      chk("prot refused", 24'(!expGo), 24'(protCmdRefused));
      protCmdReq = 1'b0;
      host.tick(2);
   endtask
   // Write enable, then a protected command starts an operation
   task automatic startOp;
      host.frame(`OPC_WRITE_ENABLE, 8, 32'h0, 0, 1'b0);
      protReq(1'b1);
   endtask
   task automatic waitLock;
      for (int i = 0; i < 100 && resumeInEffect === 1'b1; i++) host.tick(1);
      strobe(DONE);
   endtask
   task automatic tWriteEnable;
      host.frame(`OPC_WRITE_ENABLE, 7, 32'h0, 0, 1'b0);
      chk("latch short", 24'h0, 24'(status.writeLatchFlag));
      protReq(1'b0);
      host.frame(`OPC_WRITE_ENABLE, 8, 32'h0, 0, 1'b0);
      chk("latch", 24'h1, 24'(status.writeLatchFlag));
      strobe(LATCH_CLR);
      chk("latch clear", 24'h0, 24'(status.writeLatchFlag));
   endtask
   task automatic tResume;
      host.frame(`OPC_RESUME_B, 8, 32'h0, 0, 1'b0);
      chk("idle resume", 24'h0, 24'(resumeInEffect));
      startOp();
      suspendIsProgram = 1'b1;
      strobe(SUSPEND);
      chk("suspend", 24'h6, 24'(status[4:1]));
      strobe(LATCH_CLR);
      host.frame(`OPC_RESUME_A, 8, 32'h0, 0, 1'b0);
      chk("resume", 24'h1, 24'(status[4:1]));
      strobe(SUSPEND);
      chk("lockout", 24'h1, 24'(status[4:1]));
      waitLock();
      chk("done", 24'h0, 24'(status[4:1]));
   endtask
   task automatic tNested;
      startOp();
      suspendIsProgram = 1'b0;
      strobe(SUSPEND);
      chk("erase suspend", 24'ha, 24'(status[4:1]));
      startOp();
      suspendIsProgram = 1'b1;
      strobe(SUSPEND);
      chk("both suspend", 24'he, 24'(status[4:1]));
      host.frame(`OPC_RESUME_B, 8, 32'h0, 0, 1'b0);
      chk("program first", 24'hb, 24'(status[4:1]));
      waitLock();
      host.frame(`OPC_RESUME_A, 5, 32'h0, 0, 1'b0);
      chk("short resume", 24'ha, 24'(status[4:1]));
      host.frame(`OPC_RESUME_A, 8, 32'h0, 0, 1'b0);
      chk("erase resume", 24'h1, 24'(status[4:1]));
      waitLock();
   endtask
   // Quad read burst of sixteen steps from a start address
   task automatic burst(input logic [7:0] op, input logic [23:0] start, input logic [23:0] mask);
      host.frame(op, 8, 32'h0, 0, 1'b1);
      host.tick(4);
      chk("quad read", 24'h1, 24'(quadReadActive));
      loadAddr = start;
      addrLoad = 1'b1;
      host.tick(1);
      addrLoad = 1'b0;
      addrStep = 1'b1;
      for (int i = 1; i <= 16; i++) begin
         host.tick(1);
         chk("addr", (start & ~mask) | ((start + 24'(i)) & mask), readAddr);
      end
      addrStep = 1'b0;
      host.endFrame();
   endtask
   task automatic tWrap;
      for (int c = 0; c < 4; c++) begin
         host.frame(`OPC_SET_WRAP, 8, {24'habcdef, 1'b1, 2'(c), 1'b0, 4'hf}, 8, 1'b0);
         chk("wrap", 24'(c * 2), 24'(wrapSettingBits));
      end
      host.frame(`OPC_SET_WRAP, 8, 32'h20, 7, 1'b0);
      chk("wrap abort", 24'h6, 24'(wrapSettingBits));
      host.frame(`OPC_SET_WRAP, 8, 32'h20, 8, 1'b0);
      burst(`OPC_QUAD_READ_A, 24'h001004, 24'h00000f);
      chk("wrap kept", 24'h2, 24'(wrapSettingBits));
      host.frame(`OPC_SET_WRAP, 8, 32'h10, 8, 1'b0);
      chk("wrap off", 24'h1, 24'(wrapSettingBits));
      burst(`OPC_QUAD_READ_B, 24'h00100c, 24'hffffff);
   endtask
   task automatic tallyAndFinish;
      $display("mismatches %0d comparisons %0d", errCount, testsRun);
      if (errCount == 0 && testsRun > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   initial begin
      #100000;
      errCount++;
      tallyAndFinish();
   end
   initial begin
      rst = 1'b1;
      suspendReq = 1'b0;
      suspendIsProgram = 1'b0;
      opDone = 1'b0;
      writeLatchClear = 1'b0;
      protCmdReq = 1'b0;
      addrLoad = 1'b0;
      addrStep = 1'b0;
      loadAddr = 24'h000000;
      host.tick(10);
      rst = 1'b0;
      host.tick(2);
      chk("reset status", 24'h0, 24'(status));
      chk("reset wrap", 24'(`WRAP_RESET), 24'(wrapSettingBits));
      tWriteEnable();
      tResume();
      tNested();
      tWrap();
      tallyAndFinish();
   end
endmodule // flash_resume_wrap_write_enable_tb_top
`default_nettype wire
